// ==== src/usr_pkg.sv ====
package usr_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_MHZ          = 250;
	localparam int unsigned IDLE_SUSPEND_US  = 3000;
	localparam int unsigned MIN_SLEEP_US     = 5000;
	localparam int unsigned CLK_OFF_DELAY_US = 2000;
	localparam int unsigned RESUME_MAX_US    = 15000;
	localparam int unsigned REMOTE_K_US      = 10000;
	localparam int unsigned IDLE_SUSPEND_CYC  = IDLE_SUSPEND_US * CLK_MHZ;
	localparam int unsigned MIN_SLEEP_CYC     = MIN_SLEEP_US * CLK_MHZ;
	localparam int unsigned CLK_OFF_DELAY_CYC = CLK_OFF_DELAY_US * CLK_MHZ;
	localparam int unsigned RESUME_MAX_CYC    = RESUME_MAX_US * CLK_MHZ;
	localparam int unsigned REMOTE_K_CYC      = REMOTE_K_US * CLK_MHZ;
	localparam int unsigned STABLE_CYC        = 1000;

	// ---------------------------------------------------------------
	// Registers and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] UNLOCK_CODE        = 16'haa37;
	localparam logic        POWER_DOWN_RST     = 1'b1;
	localparam logic        PULLUP_CONNECT_RST = 1'b0;
	localparam logic        CLOCK_RUN_RST      = 1'b1;

	// ---------------------------------------------------------------
	// Power states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		USR_AWAKE,
		USR_SLEEP,
		USR_WAKE_OSC,
		USR_WAKE_RUN
	} usr_state_t;

endpackage : usr_pkg

// ==== src/usr_cnt.sv ====
`timescale 1ns/10ps
`default_nettype none

// Up-counter that raises done after LIMIT cycles of run; dropping run restarts.
module usr_cnt #(
	parameter int unsigned LIMIT = 16
) (
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic run_i,
	output logic      done_o
);

	localparam int unsigned W = $clog2(LIMIT + 1);

	initial begin
		if (LIMIT < 1)
			$error("usr_cnt: LIMIT must be at least one");
	end

	logic [W-1:0] cnt_q;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
		end else if (!run_i) begin
			cnt_q <= '0;
		end else if (cnt_q != W'(LIMIT)) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	assign done_o = run_i && (cnt_q == W'(LIMIT));

endmodule : usr_cnt

`default_nettype wire

// ==== src/usr_lock.sv ====
`timescale 1ns/10ps
`default_nettype none

// Register write lock armed at suspend, released by the unlock code.
module usr_lock (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        arm_i,
	input  wire logic        unlock_wr_i,
	input  wire logic [15:0] unlock_data_i,
	output logic             locked_o
);

	logic locked_q;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			locked_q <= 1'b0;
		end else if (arm_i) begin
			locked_q <= 1'b1;
		end else if (unlock_wr_i && unlock_data_i == usr_pkg::UNLOCK_CODE) begin
			locked_q <= 1'b0;
		end
	end

	assign locked_o = locked_q;

	AST_UNLOCK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!arm_i && unlock_wr_i && unlock_data_i == usr_pkg::UNLOCK_CODE
		|=> !locked_q)
		else $error("lock not released by unlock code");

	AST_ARM: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		arm_i |=> locked_q)
		else $error("lock not armed");

endmodule : usr_lock

`default_nettype wire

// ==== src/usr_suspend_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none

module usr_suspend_ctrl #(
	parameter int unsigned IDLE_CYC   = usr_pkg::IDLE_SUSPEND_CYC,
	parameter int unsigned SLEEP_CYC  = usr_pkg::MIN_SLEEP_CYC,
	parameter int unsigned CLKOFF_CYC = usr_pkg::CLK_OFF_DELAY_CYC,
	parameter int unsigned STABLE_CYC = usr_pkg::STABLE_CYC,
	parameter int unsigned KDRIVE_CYC = usr_pkg::REMOTE_K_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        bus_j_i,
	input  wire logic        bus_k_i,
	input  wire logic        vbus_i,
	input  wire logic        remote_wake_in_i,
	input  wire logic        chip_select_n_i,
	input  wire logic        osc_stable_i,
	input  wire logic        cfg_wr_i,
	input  wire logic        pullup_connect_enable_i,
	input  wire logic        sleep_request_i,
	input  wire logic        external_pullup_select_i,
	input  wire logic        internal_clock_run_i,
	input  wire logic        chip_select_wake_enable_i,
	input  wire logic        aux_clock_off_select_i,
	input  wire logic        sleep_irq_enable_i,
	input  wire logic        wake_irq_enable_i,
	input  wire logic        flag_clr_i,
	input  wire logic        unlock_wr_i,
	input  wire logic [15:0] unlock_data_i,
	input  wire logic        aux_clock_i,
	output logic             sleep_entry_flag_o,
	output logic             wake_done_flag_o,
	output logic             bus_sleep_status_o,
	output logic             irq_o,
	output logic             sleep_ind_o,
	output logic             clocks_on_o,
	output logic             osc_enable_o,
	output logic             pins_parked_o,
	output logic             aux_clock_out_o,
	output logic             drive_k_o,
	output logic             regs_locked_o,
	output logic             pullup_connect_enable_o,
	output logic             external_pullup_select_o,
	output logic             internal_clock_run_o,
	output logic             chip_select_wake_enable_o,
	output logic             aux_clock_off_select_o,
	output logic             power_down_select_o
);

	initial begin
		if (IDLE_CYC < 1 || SLEEP_CYC < 1 || CLKOFF_CYC < 1 ||
		    STABLE_CYC < 1 || KDRIVE_CYC < 1 || CLKOFF_CYC >= SLEEP_CYC)
			$error("usr_suspend_ctrl: counts must be at least one");
	end

	// ---------------------------------------------------------------
	// Configuration bits
	// ---------------------------------------------------------------
	logic locked;
	logic pullup_q, extpull_q, internal_clock_run_q, cswake_q, auxoff_q, pdsel_q;
	logic sleep_req_q;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pullup_q    <= usr_pkg::PULLUP_CONNECT_RST;
			extpull_q   <= 1'b0;
			internal_clock_run_q    <= usr_pkg::CLOCK_RUN_RST;
			cswake_q    <= 1'b0;
			auxoff_q    <= 1'b0;
			sleep_req_q <= 1'b0;
		end else if (cfg_wr_i && !locked) begin
			pullup_q    <= pullup_connect_enable_i;
			extpull_q   <= external_pullup_select_i;
			internal_clock_run_q    <= internal_clock_run_i;
			cswake_q    <= chip_select_wake_enable_i;
			auxoff_q    <= aux_clock_off_select_i;
			sleep_req_q <= sleep_request_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pdsel_q <= usr_pkg::POWER_DOWN_RST;
		end
	end

	// ---------------------------------------------------------------
	// Suspend detection
	// ---------------------------------------------------------------
	logic idle_done, susp_cond;

	usr_cnt #(.LIMIT(IDLE_CYC)) u_idle (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.run_i     (bus_j_i),
		.done_o    (idle_done)
	);

	assign susp_cond = idle_done || !vbus_i || (!pullup_q && !extpull_q);

	// ---------------------------------------------------------------
	// Power state machine
	// ---------------------------------------------------------------
	usr_pkg::usr_state_t state_q;
	logic req_fall, sleep_done, clkoff_done, stable_done, k_done;
	logic wake_ev, remote_q, in_sleep;

	assign req_fall = cfg_wr_i && !locked && sleep_req_q &&
	                  !sleep_request_i;
	assign in_sleep = (state_q == usr_pkg::USR_SLEEP);

	usr_cnt #(.LIMIT(SLEEP_CYC)) u_hold (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.run_i     (in_sleep),
		.done_o    (sleep_done)
	);

	usr_cnt #(.LIMIT(CLKOFF_CYC)) u_clkoff (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.run_i     (in_sleep),
		.done_o    (clkoff_done)
	);

	usr_cnt #(.LIMIT(STABLE_CYC)) u_stable (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.run_i     (state_q == usr_pkg::USR_WAKE_OSC && osc_stable_i),
		.done_o    (stable_done)
	);

	usr_cnt #(.LIMIT(KDRIVE_CYC)) u_kdrv (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.run_i     (state_q == usr_pkg::USR_WAKE_RUN && remote_q),
		.done_o    (k_done)
	);

	assign wake_ev = bus_k_i || remote_wake_in_i ||
	                 (cswake_q && !chip_select_n_i);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= usr_pkg::USR_AWAKE;
		end else begin
			unique case (state_q)
				usr_pkg::USR_AWAKE: begin
					if (req_fall)
						state_q <= usr_pkg::USR_SLEEP;
				end
				usr_pkg::USR_SLEEP: begin
					if (sleep_done && wake_ev)
						state_q <= usr_pkg::USR_WAKE_OSC;
				end
				usr_pkg::USR_WAKE_OSC: begin
					if (stable_done)
						state_q <= usr_pkg::USR_WAKE_RUN;
				end
				usr_pkg::USR_WAKE_RUN: begin
					if (!remote_q || k_done)
						state_q <= usr_pkg::USR_AWAKE;
				end
				default: state_q <= usr_pkg::USR_AWAKE;
			endcase
		end
	end

	// Remote wake is latched so the K drive follows the pin that woke us.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			remote_q <= 1'b0;
		end else if (in_sleep && sleep_done && wake_ev) begin
			remote_q <= !bus_k_i;
		end
	end

	logic enter, wake_start;
	assign enter      = (state_q == usr_pkg::USR_AWAKE) && req_fall;
	assign wake_start = in_sleep && sleep_done && wake_ev;

	// ---------------------------------------------------------------
	// Lock
	// ---------------------------------------------------------------
	// lock armed on entry
	usr_lock u_lock (
		.sys_clk_i     (sys_clk_i),
		.rstn_i        (rstn_i),
		.arm_i         (enter),
		.unlock_wr_i   (unlock_wr_i),
		.unlock_data_i (unlock_data_i),
		.locked_o      (locked)
	);

	// ---------------------------------------------------------------
	// Flags and outputs
	// ---------------------------------------------------------------
	logic sflag_q, wflag_q, sleep_ind_q, clk_on_q, osc_q, drive_k_q;
	logic status_q, irq_q, aux_q;

	// sleep entry flag
	// Setting wins over a clear in the same cycle.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sflag_q <= 1'b0;
		end else if (enter) begin
			sflag_q <= 1'b1;
		end else if (flag_clr_i) begin
			sflag_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wflag_q <= 1'b0;
		end else if (stable_done) begin
			wflag_q <= 1'b1;
		end else if (flag_clr_i) begin
			wflag_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sleep_ind_q <= 1'b0;
		end else if (enter && pdsel_q) begin
			sleep_ind_q <= 1'b1;
		end else if (stable_done) begin
			sleep_ind_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk_on_q <= 1'b1;
			osc_q    <= 1'b1;
		end else begin
			if (clkoff_done && !sleep_done)
				clk_on_q <= 1'b0;
			else if (stable_done)
				clk_on_q <= 1'b1;
			if (clkoff_done && !sleep_done)
				osc_q <= 1'b0;
			else if (wake_start)
				osc_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_q <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= susp_cond;
			irq_q    <= (sflag_q && sleep_irq_enable_i) ||
			            (wflag_q && wake_irq_enable_i);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drive_k_q <= 1'b0;
			aux_q     <= 1'b0;
		end else begin
			drive_k_q <= (state_q == usr_pkg::USR_WAKE_RUN) && remote_q &&
			             !k_done;
			aux_q     <= (sleep_ind_q && auxoff_q) ? 1'b0 : aux_clock_i;
		end
	end

	AST_IND_ON: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		enter |=> sleep_ind_q)
		else $error("sleep indicator not raised on entry");

	AST_HOLDOFF: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		in_sleep && !sleep_done |=> state_q != usr_pkg::USR_WAKE_OSC)
		else $error("woke before holdoff elapsed");

	AST_SFLAG: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		enter |=> sflag_q ##1 (irq_q || !sleep_irq_enable_i))
		else $error("sleep entry flag or interrupt missing");

	AST_IND_LOW: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_q == usr_pkg::USR_AWAKE && !enter |=> !sleep_ind_q)
		else $error("sleep indicator high while awake");

	AST_LOCKED: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		locked && !enter |=> $stable(internal_clock_run_q) && $stable(pullup_q))
		else $error("write accepted while locked");

	AST_AUX: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		sleep_ind_q && auxoff_q |=> !aux_q)
		else $error("aux clock not held low");

	AST_STATUS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		susp_cond |=> status_q)
		else $error("bus sleep status not reported");

	assign sleep_entry_flag_o        = sflag_q;
	assign wake_done_flag_o          = wflag_q;
	assign bus_sleep_status_o        = status_q;
	assign irq_o                     = irq_q;
	assign sleep_ind_o               = sleep_ind_q;
	assign clocks_on_o               = clk_on_q;
	assign osc_enable_o              = osc_q;
	assign pins_parked_o             = sleep_ind_q;
	assign aux_clock_out_o           = aux_q;
	assign drive_k_o                 = drive_k_q;
	assign regs_locked_o             = locked;
	assign pullup_connect_enable_o   = pullup_q;
	assign external_pullup_select_o  = extpull_q;
	assign internal_clock_run_o      = internal_clock_run_q;
	assign chip_select_wake_enable_o = cswake_q;
	assign aux_clock_off_select_o    = auxoff_q;
	assign power_down_select_o       = pdsel_q;

endmodule : usr_suspend_ctrl

`default_nettype wire

// ==== test/usr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Host and oscillator model: modes 0 idle J, 1 traffic, 2 resume K, 3 unpowered.
module usr_host_model #(
	parameter int unsigned OSC_DLY = 5
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       osc_enable_i,
	output logic            bus_j_o,
	output logic            bus_k_o,
	output logic            vbus_o,
	output logic            osc_stable_o
);
	logic [7:0] osc_cnt_q;
	logic       tog_q;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tog_q <= 1'b0;
		end else begin
			tog_q <= ~tog_q;
		end
	end

	assign bus_j_o = (mode_i == 2'd0) | ((mode_i == 2'd1) & tog_q);
	assign bus_k_o = (mode_i == 2'd2) | ((mode_i == 2'd1) & ~tog_q);
	assign vbus_o = (mode_i != 2'd3);

	// Stability is lost at once when the oscillator is stopped.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			osc_cnt_q <= 8'h00;
		end else if (!osc_enable_i) begin
			osc_cnt_q <= 8'h00;
		end else if (osc_cnt_q != 8'(OSC_DLY)) begin
			osc_cnt_q <= osc_cnt_q + 8'h01;
		end
	end
	assign osc_stable_o = osc_enable_i & (osc_cnt_q == 8'(OSC_DLY));
endmodule : usr_host_model

`default_nettype wire

// ==== test/usr_suspend_ctrl_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module usr_suspend_ctrl_tb_top;
	localparam int unsigned IDLE = 16;
	localparam int unsigned SLP  = 20;
	localparam int unsigned CKOF = 8;
	localparam int unsigned STB  = 10;
	localparam int unsigned KDRV = 12;
	logic        clk, rstn, bj, bk, vbus, rwake, csn, ostab, cfg_wr, sr;
	logic        flag_clr, unl_wr, aux_clk, s_ie, w_ie, pds;
	logic        sef, wdf, bss, irq, sind, ckon, osce, park, auxo, dk, lck;
	logic [5:0]  cfg;
	logic [4:0]  rb;
	logic [15:0] unl_data;
	logic [1:0]  hmode;
	int          num_errors, comparisons, cyc, kcnt;

	usr_host_model u_host (.sys_clk_i(clk), .rstn_i(rstn), .mode_i(hmode),
		.osc_enable_i(osce), .bus_j_o(bj), .bus_k_o(bk), .vbus_o(vbus),
		.osc_stable_o(ostab));

	usr_suspend_ctrl #(.IDLE_CYC(IDLE), .SLEEP_CYC(SLP), .CLKOFF_CYC(CKOF),
		.STABLE_CYC(STB), .KDRIVE_CYC(KDRV)) u_dut (
		.sys_clk_i(clk), .rstn_i(rstn), .bus_j_i(bj), .bus_k_i(bk),
		.vbus_i(vbus), .remote_wake_in_i(rwake), .chip_select_n_i(csn),
		.osc_stable_i(ostab), .cfg_wr_i(cfg_wr),
		.pullup_connect_enable_i(cfg[0]), .sleep_request_i(cfg[1]),
		.external_pullup_select_i(cfg[2]), .internal_clock_run_i(cfg[3]),
		.chip_select_wake_enable_i(cfg[4]), .aux_clock_off_select_i(cfg[5]),
		.sleep_irq_enable_i(s_ie), .wake_irq_enable_i(w_ie),
		.flag_clr_i(flag_clr), .unlock_wr_i(unl_wr),
		.unlock_data_i(unl_data), .aux_clock_i(aux_clk),
		.sleep_entry_flag_o(sef), .wake_done_flag_o(wdf),
		.bus_sleep_status_o(bss), .irq_o(irq), .sleep_ind_o(sind),
		.clocks_on_o(ckon), .osc_enable_o(osce), .pins_parked_o(park),
		.aux_clock_out_o(auxo), .drive_k_o(dk), .regs_locked_o(lck),
		.pullup_connect_enable_o(rb[0]), .external_pullup_select_o(rb[1]),
		.internal_clock_run_o(rb[2]), .chip_select_wake_enable_o(rb[3]),
		.aux_clock_off_select_o(rb[4]), .power_down_select_o(pds));

	function automatic logic [4:0] exp_rb(input logic [5:0] v);
		return {v[5:2], v[0]};
	endfunction : exp_rb

	task automatic give_verdict();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [15:0] e,
	                   input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [5:0] v);
		tick(1);
		cfg = v;
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
	endtask : wr

	task automatic unlock(input logic [15:0] d);
		unl_data = d;
		unl_wr = 1'b1;
		tick(1);
		unl_wr = 1'b0;
		tick(1);
	endtask : unlock

	// Kind 0 wake pin, 1 host resume, 2 chip select.
	task automatic sleep_cycle(input int kind);
		logic en;
		int   n;
		en = 1'($urandom);
		w_ie = en;
		s_ie = 1'b1;
		hmode = 2'd0;
		flag_clr = 1'b1;
		tick(1);
		flag_clr = 1'b0;
		wr({1'b1, kind == 2, 4'b0011});
		wr({1'b1, kind == 2, 4'b0001});
		tick(1);
		chk("entry", 4'hf, {sind, sef, lck, park});
		tick(1);
		chk("irq_sleep", 1'b1, irq);
		chk("aux_out", 1'b0, auxo);
		s_ie = 1'b0;
		tick(CKOF + 1);
		chk("clk_off", 2'b00, {ckon, osce});
		wr(6'b000000);
		tick(1);
		chk("locked_rb", exp_rb({1'b1, kind == 2, 4'b0001}), rb);
		rwake = 1'b1;
		tick(2);
		rwake = 1'b0;
		tick(1);
		chk("holdoff", 2'b10, {sind, osce});
		tick(SLP);
		chk("status_sleep", 1'b1, bss);
		chk("aux_out_late", 1'b0, auxo);
		kcnt = 0;
		case (kind)
			0: rwake = 1'b1;
			1: hmode = 2'd2;
			default: csn = 1'b0;
		endcase
		for (n = 0; n < 40 && osce !== 1'b1; n++) tick(1);
		chk("osc_first", 2'b10, {osce, ckon});
		for (n = 0; n < 100 && sind !== 1'b0; n++) tick(1);
		chk("woken", 3'b010, {sind, ckon, park});
		rwake = 1'b0;
		csn = 1'b1;
		hmode = 2'd1;
		tick(1);
		chk("wake_flag", 1'b1, wdf);
		tick(1);
		chk("irq_wake", en, irq);
		tick(2 * KDRV);
		chk("k_cycles", (kind == 1) ? 16'd0 : 16'(KDRV), 16'(kcnt));
		unlock(16'($urandom) & 16'hfffe);
		chk("still_locked", 1'b1, lck);
		unlock(16'haa37);
		chk("unlocked", 1'b0, lck);
		wr(6'b001001);
		tick(1);
		chk("rb_after", exp_rb(6'b001001), rb);
	endtask : sleep_cycle

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		aux_clk = 1'b0;
		forever #3 aux_clk = ~aux_clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (dk === 1'b1) kcnt++;
		if (cyc == 4000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		logic [5:0] v;
		{rstn, rwake, cfg_wr, sr, flag_clr, unl_wr, s_ie, w_ie} = 8'h00;
		{csn, cfg, unl_data, hmode, num_errors, comparisons, cyc} = '0;
		csn = 1'b1;
		hmode = 2'd1;
		kcnt = 0;
		void'($urandom(43397));
		repeat (5) @(posedge clk);
		#1;
		rstn = 1'b1;
		chk("reset", 9'h0f0, {sind, ckon, osce, rb[2], pds, lck, sef, wdf, rb[0]});
		repeat (6) begin
			v = 6'($urandom) & 6'h3d;
			wr(v);
			tick(1);
			chk("readback", exp_rb(v), rb);
		end
		wr(6'b000001);
		tick(4);
		chk("status_traffic", 1'b0, bss);
		hmode = 2'd0;
		tick(3);
		chk("status_short_idle", 1'b0, bss);
		tick(IDLE + 2);
		chk("status_idle", 1'b1, bss);
		hmode = 2'd1;
		tick(3);
		chk("status_live", 1'b0, bss);
		hmode = 2'd3;
		tick(3);
		chk("status_vbus", 1'b1, bss);
		hmode = 2'd1;
		tick(3);
		chk("status_vbus_back", 1'b0, bss);
		wr(6'b000000);
		tick(2);
		chk("status_disc", 1'b1, bss);
		wr(6'b000100);
		tick(2);
		chk("status_ext", 1'b0, bss);
		for (int k = 0; k < 3; k++) sleep_cycle(k);
		give_verdict();
	end
endmodule : usr_suspend_ctrl_tb_top

`default_nettype wire
